// ==== pin_block_pkg.sv ====
// Constants shared by the general-purpose pin block
package pin_block_pkg;
    localparam logic [6:0] LEVEL_ADDR      = 7'h10;
    localparam logic [6:0] FUNC_ADDR       = 7'h11;
    localparam logic [7:0] LEVEL_RESET     = 8'h00;
    localparam logic [7:0] FUNC_RESET      = 8'h00;
    localparam int         DIR_LSB         = 4;
    localparam int         VALUE_LSB       = 0;
    localparam int         SELECT_LSB      = 0;
    localparam int         NUM_PINS        = 4;
    localparam int         CMD_READ_BIT    = 7;
    localparam logic [3:0] CMD_LAST_COUNT  = 4'h7;
    localparam logic [3:0] FRAME_LAST_COUNT = 4'hF;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;
endpackage : pin_block_pkg

// ==== pin_block.sv ====
// General-purpose pin block with its serial register port
// Notes on behaviour
// - Level register bits 7:4: 0 output, 1 input
// - Bits 3:0 drive digital outputs, report digital input levels
// - Function bits 3:0 pick analog or digital
// - Six-input variant: pins disabled until selected
// - Level register at 10h, resets to 00h
// - Function register at 11h, resets to 00h
// - Serial port runs in mode 1
// - Clock idles low; data changes on rise
// - Incoming serial data sampled on fall
`timescale 1ns/1ns
`default_nettype none
module pin_block
    import pin_block_pkg::*;
#(
    parameter bit SIX_INPUT_VARIANT = 1'b0
) (
    // Core clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Serial port, link side
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                mosi,
    output var  logic                miso,
    output var  logic                miso_oe,
    // Pins
    input  wire logic [NUM_PINS-1:0] pin_in,
    output var  logic [NUM_PINS-1:0] pin_out,
    output var  logic [NUM_PINS-1:0] pin_oe,
    output var  logic [NUM_PINS-1:0] pin_analog_en
);
    typedef struct packed {
        logic [NUM_PINS-1:0] pin_s1;
        logic [NUM_PINS-1:0] pin_s2;
        logic [2:0]          wr_sync;
        logic [1:0]          ack_sync;
        logic                req;
        logic [15:0]         snap;
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] val;
        logic [NUM_PINS-1:0] fsel;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] ana;
    } core_state_t;

    typedef struct packed {
        // Set by the first fall of a frame, for the count check
        logic       live;
        logic [3:0] cnt;
        logic [6:0] shreg;
        logic [7:0] cmd;
    } frame_state_t;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        ack;
        logic [15:0] mirror;
        logic        wr_tgl;
        logic [6:0]  wr_addr;
        logic [7:0]  wr_data;
    } link_state_t;

    typedef struct packed {
        logic miso;
        logic oe;
    } launch_state_t;

    initial begin
        if (SIX_INPUT_VARIANT !== 1'b0 && SIX_INPUT_VARIANT !== 1'b1) begin
            $error("SIX_INPUT_VARIANT must be 0 or 1");
        end
    end

    core_state_t   core_reg, core_next;
    frame_state_t  frame_reg, frame_next;
    link_state_t   link_reg, link_next;
    launch_state_t launch_reg, launch_next;
    logic          frame_clr;
    logic          wr_pulse;
    logic [7:0]    level_image;
    logic [7:0]    rd_byte;

    // Frame state lives only while select is low
    assign frame_clr = rst | cs_n;

    // ---------------- Core clock domain ----------------
    assign wr_pulse = core_reg.wr_sync[1] ^ core_reg.wr_sync[2];

    always_comb begin
        core_next = core_reg;
        core_next.pin_s1 = pin_in;
        core_next.pin_s2 = core_reg.pin_s1;
        core_next.wr_sync = {core_reg.wr_sync[1:0], link_reg.wr_tgl};
        core_next.ack_sync = {core_reg.ack_sync[0], link_reg.ack};
        if (wr_pulse) begin
            if (link_reg.wr_addr == LEVEL_ADDR) begin
                core_next.dir = link_reg.wr_data[DIR_LSB +: NUM_PINS];
                // Stored even for inputs; drive is gated by direction
                core_next.val = link_reg.wr_data[VALUE_LSB +: NUM_PINS];
            end else if (link_reg.wr_addr == FUNC_ADDR) begin
                // Upper bits are read-only and dropped
                core_next.fsel = link_reg.wr_data[SELECT_LSB +: NUM_PINS];
            end
        end
        // Drive only digital outputs
        core_next.oe = core_reg.fsel & ~core_reg.dir;
        core_next.out = core_reg.val & core_next.oe;
        if (SIX_INPUT_VARIANT) begin
            core_next.ana = '0;
        end else begin
            core_next.ana = ~core_reg.fsel;
        end
        // New snapshot only once the link has taken the last one
        if (core_reg.ack_sync[1] == core_reg.req) begin
            core_next.snap = {4'h0, core_reg.fsel, level_image};
            core_next.req = ~core_reg.req;
        end
        if (rst) begin
            core_next = '0;
            core_next.dir = LEVEL_RESET[DIR_LSB +: NUM_PINS];
            core_next.val = LEVEL_RESET[VALUE_LSB +: NUM_PINS];
            core_next.fsel = FUNC_RESET[SELECT_LSB +: NUM_PINS];
            core_next.ana = SIX_INPUT_VARIANT ? '0 : '1;
        end
    end

    // Digital inputs report the seen level, others the stored one
    always_comb begin
        level_image[DIR_LSB +: NUM_PINS] = core_reg.dir;
        level_image[VALUE_LSB +: NUM_PINS] =
            (core_reg.fsel & core_reg.dir & core_reg.pin_s2) |
            (~(core_reg.fsel & core_reg.dir) & core_reg.val);
    end

    always_ff @(posedge core_clk) begin
        core_reg <= core_next;
    end

    assign pin_out = core_reg.out;
    assign pin_oe = core_reg.oe;
    assign pin_analog_en = core_reg.ana;

    // ---------------- Link clock domain ----------------
    always_comb begin
        frame_next = frame_reg;
        frame_next.live = 1'b1;
        frame_next.cnt = frame_reg.cnt + 4'h1;
        frame_next.shreg = {frame_reg.shreg[5:0], mosi};
        if (frame_reg.cnt == CMD_LAST_COUNT) begin
            frame_next.cmd = {frame_reg.shreg, mosi};
        end
    end

    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    always_comb begin
        link_next = link_reg;
        link_next.req_s1 = core_reg.req;
        link_next.req_s2 = link_reg.req_s1;
        // Snapshot is held still by the core until acknowledged
        if (link_reg.req_s2 != link_reg.ack) begin
            link_next.mirror = core_reg.snap;
            link_next.ack = link_reg.req_s2;
        end
        if (!cs_n && frame_reg.cnt == FRAME_LAST_COUNT
                && !frame_reg.cmd[CMD_READ_BIT]) begin
            link_next.wr_addr = frame_reg.cmd[6:0];
            link_next.wr_data = {frame_reg.shreg, mosi};
            link_next.wr_tgl = ~link_reg.wr_tgl;
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    always_comb begin
        if (!frame_reg.cmd[CMD_READ_BIT]) begin
            rd_byte = UNMAPPED_READ;
        end else if (frame_reg.cmd[6:0] == LEVEL_ADDR) begin
            rd_byte = link_reg.mirror[7:0];
        end else if (frame_reg.cmd[6:0] == FUNC_ADDR) begin
            rd_byte = link_reg.mirror[15:8];
        end else begin
            rd_byte = UNMAPPED_READ;
        end
    end

    always_comb begin
        launch_next.oe = 1'b1;
        launch_next.miso = 1'b0;
        if (frame_reg.cnt[3]) begin
            launch_next.miso = rd_byte[3'h7 - frame_reg.cnt[2:0]];
        end
    end

    // Launch on the rising edge, half a period before sampling
    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            launch_reg <= '0;
        end else begin
            launch_reg <= launch_next;
        end
    end

    assign miso = launch_reg.miso;
    assign miso_oe = launch_reg.oe;

    // ---------------- Checks ----------------
    a_reset_values: assert property (@(posedge core_clk)
        $past(rst) |-> core_reg.dir == '0 && core_reg.val == '0)
        else $error("level register not zero after reset");

    a_func_reset: assert property (@(posedge core_clk)
        $past(rst) |-> core_reg.fsel == '0)
        else $error("function register not zero after reset");

    a_level_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_pulse && link_reg.wr_addr == LEVEL_ADDR
        |=> core_reg.dir == $past(link_reg.wr_data[7:4]))
        else $error("direction not taken from write");

    a_func_upper_zero: assert property (@(posedge core_clk)
        disable iff (rst) wr_pulse && link_reg.wr_addr == FUNC_ADDR
        |=> core_reg.fsel == $past(link_reg.wr_data[SELECT_LSB +: NUM_PINS])
        && core_reg.snap[15:12] == 4'h0)
        else $error("function write not taken as four bits");

    a_drive_config: assert property (@(posedge core_clk) disable iff (rst)
        ##1 pin_oe == $past(core_reg.fsel & ~core_reg.dir)
        && pin_out == $past(core_reg.val & ~core_reg.dir & core_reg.fsel))
        else $error("pin drive does not follow registers");

    a_input_no_drive: assert property (@(posedge core_clk)
        disable iff (rst) core_reg.dir[0] |=> !pin_oe[0] ##1 1'b1)
        else $error("input pin is driven");

    a_analog_variant: assert property (@(posedge core_clk)
        disable iff (rst) ##1 pin_analog_en ==
        (SIX_INPUT_VARIANT ? 4'h0 : ~$past(core_reg.fsel)))
        else $error("analog enable does not follow function bits");

    a_bit_count: assert property (@(negedge sclk) disable iff (frame_clr)
        frame_reg.live |-> frame_reg.cnt == $past(frame_reg.cnt) + 4'h1)
        else $error("bit counter skipped a falling edge");

    a_miso_idle: assert property (@(posedge sclk) disable iff (frame_clr)
        !frame_reg.cnt[3] |=> !miso)
        else $error("data driven during command byte");
endmodule : pin_block
`default_nettype wire

// ==== host_model.sv ====
// Serial host model: mode 1 master driving the pin block's port
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Serial lines
    output var  logic       sclk,
    output var  logic       cs_n,
    output var  logic       mosi,
    input  wire logic       miso,
    // Read results
    output var  logic       rd_done,
    output var  logic [7:0] rd_data
);
    localparam int HALF = 80;

    initial begin
        sclk    = 1'b0;
        // Low at start so deselect gives a clean clearing edge
        cs_n    = 1'b0;
        mosi    = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
        #1;
        cs_n    = 1'b1;
    end

    // Fewer than 16 bits aborts the frame; slow stretches each low phase
    task automatic frame(input logic [15:0] word, input int nbits,
                         input int slow);
        cs_n = 1'b0;
        // Odd offset keeps serial edges clear of core edges
        #(HALF + 3);
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b1;
            mosi = word[15-i];
            #(HALF);
            sclk = 1'b0;
            if (i > 7) rd_data[15-i] = miso;
            #(HALF + slow);
        end
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        mosi = ~mosi;
        // Deselect gap keeps frames apart and lets miso_oe clear
        #(HALF);
        rd_done = word[15] && nbits == 16;
        #(HALF);
        rd_done = 1'b0;
    endtask : frame
endmodule : host_model
`default_nettype wire

// ==== pin_block_test.sv ====
// Testbench for the general-purpose pin block
`timescale 1ns/1ns
`default_nettype none
module pin_block_test;
    import pin_block_pkg::*;
    logic                core_clk;
    logic                rst;
    logic                sclk;
    logic                cs_n;
    logic                mosi;
    logic                miso;
    logic                rd_done;
    logic [7:0]          rd_data;
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_PINS-1:0] pin_analog_en;
    logic [NUM_PINS-1:0] pin_out_six;
    logic [NUM_PINS-1:0] pin_oe_six;
    logic [NUM_PINS-1:0] pin_analog_en_six;
    logic                miso_oe;
    bit                  armed;
    logic [7:0]          exp_q[$];
    logic [7:0]          lvl;
    logic [3:0]          fsel;
    int                  n_fail;
    int                  check_count;

    pin_block DUT (.core_clk(core_clk), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_analog_en(pin_analog_en));

    // Six-input variant on the same port, compared on its pins only
    pin_block #(.SIX_INPUT_VARIANT(1'b1)) DUT_six (.core_clk(core_clk),
        .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(),
        .miso_oe(), .pin_in(pin_in), .pin_out(pin_out_six),
        .pin_oe(pin_oe_six), .pin_analog_en(pin_analog_en_six));

    host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .rd_done(rd_done), .rd_data(rd_data));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic tally(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : tally

    task automatic compare_read(input logic [7:0] got, input logic [7:0] exp);
        tally({4'h0, got}, {4'h0, exp});
    endtask : compare_read

    task automatic compare_pins(input logic [11:0] got, input logic [11:0] exp);
        tally(got, exp);
    endtask : compare_pins

    task automatic compare_oe(input logic got, input logic exp);
        tally({11'h000, got}, {11'h000, exp});
    endtask : compare_oe

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.frame({1'b0, a, d}, 16, 0);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.frame({1'b1, a, 8'h00}, 16, $urandom_range(0, 40));
    endtask : rd

    // Pins settle a few core cycles after the frame
    task automatic pins(input logic [3:0] oe, out, an);
        repeat (10) @(negedge core_clk);
        compare_pins({pin_oe, pin_out, pin_analog_en}, {oe, out, an});
        compare_pins({pin_oe_six, pin_out_six, pin_analog_en_six},
            {oe, out, 4'h0});
    endtask : pins

    task automatic complete_run;
        $display("Compared %0d, failed %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge rd_done) begin
        compare_read(rd_data, exp_q.pop_front());
        compare_oe(miso_oe, 1'b0);
    end

    // Output enable stands through every selected bit
    always @(negedge sclk) begin
        if (armed && !cs_n) begin
            compare_oe(miso_oe, 1'b1);
        end
    end

    initial begin
        #500000;
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        rst = 1'b0;
        pin_in = 4'h0;
        void'($urandom(32'hCC8F));
        // Rising edge clears the link-side flops before any frame
        #2;
        rst = 1'b1;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        armed = 1'b1;
        pins(4'h0, 4'h0, 4'hF);
        rd(LEVEL_ADDR, LEVEL_RESET);
        rd(FUNC_ADDR, FUNC_RESET);
        rd(7'h12, UNMAPPED_READ);
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk) pin_in = 4'($urandom);
            lvl = 8'($urandom);
            fsel = 4'($urandom);
            // Upper function bits must be dropped on write
            wr(FUNC_ADDR, {4'($urandom), fsel});
            wr(LEVEL_ADDR, lvl);
            // Only digital inputs report the pin; others the stored bit
            rd(LEVEL_ADDR, {lvl[7:4], (lvl[7:4] & fsel & pin_in)
                | (~(lvl[7:4] & fsel) & lvl[3:0])});
            rd(FUNC_ADDR, {4'h0, fsel});
            pins(fsel & ~lvl[7:4], fsel & ~lvl[7:4] & lvl[3:0], ~fsel);
        end
        wr(LEVEL_ADDR, LEVEL_RESET);
        // Aborted frame and unmapped write leave the level register alone
        host.frame({1'b0, LEVEL_ADDR, 8'hF0}, 12, 0);
        wr(7'h12, 8'hFF);
        rd(LEVEL_ADDR, 8'h00);
        complete_run();
    end
endmodule : pin_block_test
`default_nettype wire
